// ===== core/erd_pkg.sv
package erd_pkg;
    // Address windows of the on-package program memory
    localparam logic [15:0] ERD_PKG_BASE = 16'hE000;
    localparam logic [15:0] ERD_PKG_TOP = 16'hFFFF;
    localparam logic [15:0] ERD_EMU2K_BASE = 16'hF800;
    localparam logic [15:0] ERD_EMU4K_BASE = 16'hF000;
    localparam logic [15:0] ERD_EMU2K_GAP_TOP = 16'hF7FF;
    localparam logic [15:0] ERD_EMU4K_GAP_TOP = 16'hEFFF;
    localparam logic [15:0] ERD_VEC_BASE = 16'hFFF0;
    localparam logic [15:0] ERD_RST_VEC_HI = 16'hFFFE;
    localparam logic [15:0] ERD_RST_VEC_LO = 16'hFFFF;
    // Operating mode codes
    localparam logic [2:0] ERD_MODE0 = 3'h0;
    localparam logic [2:0] ERD_MODE1 = 3'h1;
    localparam logic [2:0] ERD_MODE2 = 3'h2;
    localparam logic [2:0] ERD_MODE3 = 3'h3;
    localparam logic [2:0] ERD_MODE4 = 3'h4;
    localparam logic [2:0] ERD_MODE5 = 3'h5;
    localparam logic [2:0] ERD_MODE6 = 3'h6;
    localparam logic [2:0] ERD_MODE7 = 3'h7;
    // Emulation size select
    typedef enum logic [1:0] {
        ERD_EMU_FULL = 2'h0,
        ERD_EMU_2K = 2'h1,
        ERD_EMU_4K = 2'h2
    } erd_emu_e;
    // Reset vector fetch takes two accesses
    localparam logic [1:0] ERD_VEC_FETCHES = 2'h2;
endpackage

// ===== core/erd_mode_latch.sv
`timescale 1ns/100ps
module erd_mode_latch
    import erd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Strap pins
    input wire logic [2:0] mode_pins_i,
    input wire logic [1:0] emu_pins_i,
    // Captured values
    output logic [2:0] mode_o,
    output logic [1:0] emu_o,
    output logic valid_o
);
    typedef struct packed {
        logic [2:0] s1_mode;
        logic [2:0] s2_mode;
        logic [1:0] s1_emu;
        logic [1:0] s2_emu;
        logic [1:0] settle;
        logic [2:0] mode;
        logic [1:0] emu;
        logic valid;
    } erd_latch_s;

    erd_latch_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1_mode = mode_pins_i;
        st_d.s2_mode = st_q.s1_mode;
        st_d.s1_emu = emu_pins_i;
        st_d.s2_emu = st_q.s1_emu;
        // Wait for synchroniser to fill before capture
        if (!st_q.valid) begin
            if (st_q.settle == 2'h2) begin
                st_d.mode = st_q.s2_mode;
                st_d.emu = st_q.s2_emu;
                st_d.valid = 1'b1;
            end else begin
                st_d.settle = st_q.settle + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign mode_o = st_q.mode;
    assign emu_o = st_q.emu;
    assign valid_o = st_q.valid;

    mode_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        valid_o |=> valid_o && $stable(mode_o) && $stable(emu_o))
        else $error("mode changed after capture");
endmodule

// ===== core/erd_decode.sv
`timescale 1ns/100ps
module erd_decode
    import erd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Mode straps
    input wire logic [2:0] mode_pins_i,
    input wire logic [1:0] emu_pins_i,
    // Processor access
    input wire logic [15:0] addr_i,
    input wire logic access_i,
    input wire logic rnw_i,
    // Decode results
    output logic pkg_sel_o,
    output logic ext_sel_o,
    output logic port_drive_o,
    output logic gap_hit_o,
    output logic ready_o
);
    logic [2:0] mode;
    logic [1:0] emu;
    logic mode_ok;

    erd_mode_latch u_latch (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .mode_pins_i(mode_pins_i),
        .emu_pins_i(emu_pins_i),
        .mode_o(mode),
        .emu_o(emu),
        .valid_o(mode_ok)
    );

    typedef struct packed {
        logic [1:0] vec_left;
        logic pkg_sel;
        logic ext_sel;
        logic port_drive;
        logic gap_hit;
        logic ready;
    } erd_dec_s;

    erd_dec_s st_q, st_d;

    function automatic logic is_expanded(input logic [2:0] m);
        return (m == ERD_MODE0) || (m == ERD_MODE1) || (m == ERD_MODE6);
    endfunction

    function automatic logic [15:0] prog_base(input logic [1:0] e);
        unique case (e)
            ERD_EMU_2K: return ERD_EMU2K_BASE;
            ERD_EMU_4K: return ERD_EMU4K_BASE;
            default: return ERD_PKG_BASE;
        endcase
    endfunction

    logic in_pkg;
    logic in_prog;
    logic rom_off;
    logic vec_ext;
    logic pkg_hit;

    always_comb begin
        in_pkg = addr_i >= ERD_PKG_BASE;
        in_prog = addr_i >= prog_base(emu);
        rom_off = (mode == ERD_MODE2) || (mode == ERD_MODE3) || (mode == ERD_MODE4);
        vec_ext = ((mode == ERD_MODE1) && (addr_i >= ERD_VEC_BASE))
            || ((mode == ERD_MODE0) && (st_q.vec_left != 2'h0)
                && (addr_i >= ERD_RST_VEC_HI));
        // Expanded modes keep the window internal, except mode 1 vectors and pending mode 0 reset vector fetches
        pkg_hit = in_pkg && !rom_off && !vec_ext;
        st_d = st_q;
        st_d.ready = mode_ok;
        st_d.pkg_sel = access_i && mode_ok && pkg_hit;
        st_d.ext_sel = access_i && mode_ok && !pkg_hit && (is_expanded(mode) || rom_off);
        // Gap marks accesses an outside device must not answer
        st_d.gap_hit = access_i && mode_ok && is_expanded(mode) && in_pkg
            && !in_prog && !rom_off;
        st_d.port_drive = access_i && mode_ok && rnw_i
            && !(pkg_hit && mode == ERD_MODE0);
        if (access_i && mode_ok && st_q.vec_left != 2'h0
            && (addr_i == ERD_RST_VEC_HI || addr_i == ERD_RST_VEC_LO)) begin
            st_d.vec_left = st_q.vec_left - 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= '{vec_left: ERD_VEC_FETCHES, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign pkg_sel_o = st_q.pkg_sel;
    assign ext_sel_o = st_q.ext_sel;
    assign port_drive_o = st_q.port_drive;
    assign gap_hit_o = st_q.gap_hit;
    assign ready_o = st_q.ready;

    rom_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && rom_off && access_i) |=> !pkg_sel_o)
        else $error("internal decode active with rom disabled");
    mode1_vec_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && mode == ERD_MODE1 && access_i && addr_i >= ERD_VEC_BASE)
        |=> ext_sel_o && !pkg_sel_o)
        else $error("mode 1 vector not external");
    mode0_port_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && mode == ERD_MODE0 && access_i && pkg_hit) |=> !port_drive_o)
        else $error("mode 0 drove on-package data");
    pkg_space_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && access_i && addr_i < ERD_PKG_BASE) |=> !pkg_sel_o)
        else $error("package select below window");
    expand_ext_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && is_expanded(mode) && access_i && addr_i < ERD_PKG_BASE)
        |=> ext_sel_o)
        else $error("expanded mode not external");
    emu_prog_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && (mode == ERD_MODE5 || mode == ERD_MODE7) && access_i
         && addr_i >= prog_base(emu)) |=> pkg_sel_o)
        else $error("emulated program space not internal");
    gap_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && is_expanded(mode) && emu == ERD_EMU_2K && access_i
         && addr_i >= ERD_PKG_BASE && addr_i <= ERD_EMU2K_GAP_TOP) |=> gap_hit_o)
        else $error("gap window not flagged");
    vec_once_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && mode == ERD_MODE0 && st_q.vec_left == 2'h0 && access_i
         && addr_i == ERD_RST_VEC_HI) |=> pkg_sel_o)
        else $error("vector stayed external after fetch");

    // Steps of the mode 0 reset vector hand-off
    sequence vec_pend_s;
        mode_ok && mode == ERD_MODE0 && st_q.vec_left != 2'h0;
    endsequence
    sequence vec_hit_s;
        access_i && addr_i >= ERD_RST_VEC_HI;
    endsequence
    sequence ext_only_s;
        ext_sel_o && !pkg_sel_o && !gap_hit_o;
    endsequence
    sequence quiet_s;
        !pkg_sel_o && !ext_sel_o && !port_drive_o && !gap_hit_o;
    endsequence

    vec_ext_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (vec_pend_s ##0 vec_hit_s) |=> ext_only_s)
        else $error("pending vector fetch not external");
    vec_count_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (vec_pend_s ##0 vec_hit_s) |=> (st_q.vec_left == $past(st_q.vec_left) - 2'h1))
        else $error("vector fetch not counted");

    // Before capture the straps are unknown, so nothing may be selected
    not_ready_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !mode_ok |=> quiet_s)
        else $error("decode active before mode capture");
    idle_quiet_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !access_i |=> quiet_s)
        else $error("decode active without access");
    sel_excl_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        pkg_sel_o |-> !ext_sel_o)
        else $error("both memory selects active");
    ready_rise_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_ok |=> ready_o)
        else $error("ready did not follow capture");
    ready_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ready_o |=> ready_o)
        else $error("ready dropped before reset");

    // Data port drive only for reads, and never for mode 0 on-package hits
    write_port_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (access_i && !rnw_i) |=> !port_drive_o)
        else $error("data port driven on write");
    read_port_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && access_i && rnw_i && mode != ERD_MODE0) |=> port_drive_o)
        else $error("read data not shown on port");

    gap_4k_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && is_expanded(mode) && emu == ERD_EMU_4K && access_i
         && addr_i >= ERD_PKG_BASE && addr_i <= ERD_EMU4K_GAP_TOP) |=> gap_hit_o)
        else $error("4k gap window not flagged");
    emu_top_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && access_i && addr_i >= prog_base(emu)) |=> !gap_hit_o)
        else $error("program space flagged as gap");
    single_gap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && !is_expanded(mode)) |=> !gap_hit_o)
        else $error("gap flagged outside expanded modes");
    single_below_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && (mode == ERD_MODE5 || mode == ERD_MODE7) && access_i
         && addr_i < ERD_PKG_BASE) |=> !pkg_sel_o && !ext_sel_o)
        else $error("single chip mode selected a memory");
    rom_off_ext_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && rom_off && access_i) |=> ext_sel_o)
        else $error("rom-less access not external");
    mode1_pkg_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && mode == ERD_MODE1 && access_i && addr_i >= ERD_PKG_BASE
         && addr_i < ERD_VEC_BASE) |=> pkg_sel_o)
        else $error("mode 1 window below vectors not internal");
    mode6_pkg_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_ok && mode == ERD_MODE6 && access_i && addr_i >= ERD_PKG_BASE)
        |=> pkg_sel_o)
        else $error("mode 6 window not internal");
endmodule

// ===== sim/erd_ext_model.sv
`timescale 1ns/100ps
module erd_ext_model
    import erd_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Bus from the decoder
    input wire logic [15:0] addr_i,
    input wire logic ext_sel_i,
    // Answer
    output logic [7:0] rdata_o,
    output logic ack_o
);
    logic [15:0] addr_q = 16'h0000;
    logic [7:0] spin_q = 8'h00;
    always_ff @(posedge clk_i) begin
        addr_q <= addr_i;
        spin_q <= spin_q + 8'h01;
    end
    // Nothing is mapped from E000 below the vector area, so stray selects go unanswered
    assign ack_o = ext_sel_i && (addr_q < ERD_PKG_BASE || addr_q >= ERD_VEC_BASE);
    // Unanswered bus shows a moving pattern, never the last value
    assign rdata_o = ack_o ? addr_q[7:0] : spin_q;
endmodule

// ===== sim/test_emulation_rom_space_decode.sv
`timescale 1ns/100ps
module test_emulation_rom_space_decode
    import erd_pkg::*;
;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [2:0] mode_pins_i = 3'h0;
    logic [1:0] emu_pins_i = 2'h0;
    logic [15:0] addr_i = 16'h0000;
    logic access_i = 1'b0;
    logic rnw_i = 1'b1;
    logic pkg_sel_o, ext_sel_o, port_drive_o, gap_hit_o, ready_o, ext_ack;
    logic [7:0] ext_rdata;
    int n_mismatch = 0;
    int compares = 0;
    always #5 clk_i = ~clk_i;
    erd_decode erd_decode_inst (.clk_i(clk_i), .nrst_i(nrst_i), .mode_pins_i(mode_pins_i),
        .emu_pins_i(emu_pins_i), .addr_i(addr_i), .access_i(access_i), .rnw_i(rnw_i),
        .pkg_sel_o(pkg_sel_o), .ext_sel_o(ext_sel_o), .port_drive_o(port_drive_o),
        .gap_hit_o(gap_hit_o), .ready_o(ready_o));
    erd_ext_model erd_ext_model_inst (.clk_i(clk_i), .addr_i(addr_i), .ext_sel_i(ext_sel_o),
        .rdata_o(ext_rdata), .ack_o(ext_ack));
    task finish_test;
        $display("Counts: compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task chk_data(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Mode straps only count at reset, so each mode needs a fresh reset
    task start(input logic [2:0] m, input logic [1:0] e);
        int i;
        @(posedge clk_i);
        nrst_i <= 1'b0;
        mode_pins_i <= m;
        emu_pins_i <= e;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (i = 0; i < 12 && ready_o !== 1'b1; i++) @(posedge clk_i);
        if (ready_o !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    // Result packed as pkg, ext, port drive, gap
    task acc(input logic [15:0] a, input logic rd, input logic [3:0] exp, input string what);
        access_i <= 1'b1;
        addr_i <= a;
        rnw_i <= rd;
        @(posedge clk_i);
        access_i <= 1'b0;
        @(negedge clk_i);
        chk(what, exp, {pkg_sel_o, ext_sel_o, port_drive_o, gap_hit_o});
        // Outside parties answer only where nothing internal lives
        if (exp[2]) begin
            chk("ext ack", {3'h0, a < ERD_PKG_BASE || a >= ERD_VEC_BASE}, {3'h0, ext_ack});
            if (ext_ack === 1'b1) begin
                chk_data("ext data", a[7:0], ext_rdata);
            end
        end
        @(posedge clk_i);
    endtask
    task t_mode0;
        start(ERD_MODE0, ERD_EMU_2K);
        acc(16'hFFFE, 1'b1, 4'h6, "m0 vec hi");
        acc(16'hFFFF, 1'b1, 4'h6, "m0 vec lo");
        acc(16'hFFFE, 1'b1, 4'h8, "m0 pkg read");
        acc(16'hE100, 1'b1, 4'h9, "m0 gap");
        acc(16'h1000, 1'b1, 4'h6, "m0 ext");
        $display("mode0 test done");
    endtask
    task t_mode16;
        start(ERD_MODE1, ERD_EMU_4K);
        acc(16'hFFF0, 1'b1, 4'h6, "m1 vec");
        acc(16'hFFEF, 1'b1, 4'hA, "m1 pkg");
        acc(16'hEFFF, 1'b1, 4'hB, "m1 gap top");
        acc(16'hF000, 1'b0, 4'h8, "m1 4k base");
        acc(16'hDFFF, 1'b0, 4'h4, "m1 ext");
        start(ERD_MODE6, ERD_EMU_FULL);
        acc(16'hE000, 1'b1, 4'hA, "m6 base");
        acc(16'hDFFF, 1'b1, 4'h6, "m6 ext");
        start(ERD_MODE6, 2'h3);
        acc(16'hE000, 1'b1, 4'hA, "m6 size 3 as full");
        $display("mode1 mode6 test done");
    endtask
    task t_single;
        int m;
        for (m = 5; m <= 7; m += 2) begin
            start(m[2:0], ERD_EMU_2K);
            acc(16'hF800, 1'b1, 4'hA, "single 2k");
            acc(16'hE100, 1'b1, 4'hA, "single no gap");
            acc(16'h1000, 1'b1, 4'h2, "single below");
            start(m[2:0], ERD_EMU_4K);
            acc(16'hF000, 1'b1, 4'hA, "single 4k");
        end
        for (m = 2; m <= 4; m++) begin
            start(m[2:0], ERD_EMU_2K);
            acc(16'hF800, 1'b1, 4'h6, "romless read");
            acc(16'hE000, 1'b0, 4'h4, "romless write");
        end
        $display("single and romless test done");
    endtask
    task t_hold;
        start(ERD_MODE5, ERD_EMU_2K);
        mode_pins_i <= ERD_MODE2;
        repeat (4) @(posedge clk_i);
        acc(16'hFFFF, 1'b1, 4'hA, "mode held");
        $display("hold test done");
    endtask
    initial begin
        t_mode0();
        t_mode16();
        t_single();
        t_hold();
        finish_test();
    end
endmodule
